// ### rtl/hpsg_map.svh
/*
  Offsets, field positions, pin positions and reset values of the host port block.
  Assumes it is included by bare name from the package and the design modules.
*/
`ifndef HPSG_MAP_SVH
`define HPSG_MAP_SVH
`define HPSG_NPINS 16
// host side addresses
`define HPSG_HA_CTRL 3'h0
`define HPSG_HA_CMD 3'h1
`define HPSG_HA_STAT 3'h2
`define HPSG_HA_VEC 3'h3
`define HPSG_HA_B5 3'h5
`define HPSG_HA_B6 3'h6
`define HPSG_HA_B7 3'h7
// dsp side register port offsets
`define HPSG_DA_PCTL 4'h0
`define HPSG_DA_PDIR 4'h1
`define HPSG_DA_PDAT 4'h2
`define HPSG_DA_RX 4'h3
`define HPSG_DA_STAT 4'h4
`define HPSG_DA_FLAGS 4'h5
`define HPSG_DA_TX 4'h6
`define HPSG_DA_CACK 4'h7
// fields
`define HPSG_MODE_MSB 6
`define HPSG_MODE_LSB 1
`define HPSG_ICR_RX_REQUEST_ENABLE 0
`define HPSG_ICR_TX_REQUEST_ENABLE 1
`define HPSG_ICR_ORDER 5
`define HPSG_CMD_PEND 7
`define HPSG_ISR_RXF 0
`define HPSG_ISR_TXE 1
`define HPSG_ISR_TX_READY_FLAG 2
`define HPSG_ISR_F2 3
`define HPSG_ISR_F3 4
`define HPSG_ISR_R5 5
`define HPSG_ISR_R6 6
`define HPSG_ISR_REQ 7
// pin positions in host mode
`define HPSG_P_DMSB 7
`define HPSG_P_AMSB 10
`define HPSG_P_ALSB 8
`define HPSG_P_RD 11
`define HPSG_P_WR 12
`define HPSG_P_ACK 13
`define HPSG_P_TX_REQUEST_ENABLE 14
`define HPSG_P_RX_REQUEST_ENABLE 15
// byte lanes
`define HPSG_LANE_HI 2'h2
`define HPSG_LANE_MID 2'h1
`define HPSG_LANE_LO 2'h0
// reset values
`define HPSG_VEC_RST 8'h0F
`define HPSG_CMDV_RST 7'h32
`endif

// ### rtl/hpsg_pkg.sv
/*
  State types of the host port block.
  Assumes the map header sits in the include path.
*/
`include "hpsg_map.svh"
package hpsg_pkg;
  typedef struct packed {
    logic [`HPSG_NPINS-1:0] meta;
    logic [`HPSG_NPINS-1:0] stable;
  } hpsg_sync_t;
  typedef struct packed {
    logic [`HPSG_NPINS-1:0] drv;
    logic [`HPSG_NPINS-1:0] oe;
  } hpsg_mux_t;
  typedef struct packed {
    logic [7:0] pctl;
    logic [15:0] pdir;
    logic [15:0] pdat;
    logic [7:0] icr;
    logic cmd_pend;
    logic [6:0] cmd_vec;
    logic [7:0] vec;
    logic [23:0] txw;
    logic [23:0] rxw;
    logic [23:0] dsp_rx;
    logic tx_empty;
    logic rx_full;
    logic dsp_rx_full;
    logic [1:0] dflags;
    logic rd_d;
    logic wr_d;
    logic [7:0] hdo;
    logic hoe;
    logic tx_request_enable;
    logic rx_request_enable;
    logic request_status_flag;
    logic [23:0] rdata;
  } hpsg_core_t;
endpackage

// ### rtl/hpsg_pin_if.sv
/*
  Carrier between the core, the pin synchroniser and the pin multiplexer.
  Assumes one clock domain; the raw pins come from outside it.
*/
`timescale 1ns/10ps
`include "hpsg_map.svh"
interface hpsg_pin_if;
  logic [`HPSG_NPINS-1:0] raw;
  logic [`HPSG_NPINS-1:0] sampled;
  logic [`HPSG_NPINS-1:0] drv_host;
  logic [`HPSG_NPINS-1:0] oe_host;
  logic [`HPSG_NPINS-1:0] gpio_dir;
  logic [`HPSG_NPINS-1:0] gpio_data;
  logic host_mode;
  logic [`HPSG_NPINS-1:0] pin_out;
  logic [`HPSG_NPINS-1:0] pin_oe;
  modport sync_mp (input raw, output sampled);
  modport mux_mp (input drv_host, oe_host, gpio_dir, gpio_data, host_mode,
    output pin_out, pin_oe);
  modport core_mp (output raw, drv_host, oe_host, gpio_dir, gpio_data, host_mode,
    input sampled, pin_out, pin_oe);
endinterface

// ### rtl/hpsg_sync.sv
/*
  Two flip-flop synchroniser for all sixteen port pins.
  Assumes the pins are asynchronous to sys_clk_in.
*/
`timescale 1ns/10ps
`include "hpsg_map.svh"
module hpsg_sync (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  hpsg_pin_if.sync_mp pif
);
  hpsg_pkg::hpsg_sync_t s_r;
  hpsg_pkg::hpsg_sync_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.meta = pif.raw;
    // only the second stage reads the first
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign pif.sampled = s_r.stable;
endmodule

// ### rtl/hpsg_pinmux.sv
/*
  Pin multiplexer: general-purpose I/O or host port drive, registered.
  Assumes the core supplies mode, direction and data from its own registers.
*/
`timescale 1ns/10ps
`include "hpsg_map.svh"
module hpsg_pinmux (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  hpsg_pin_if.mux_mp pif
);
  hpsg_pkg::hpsg_mux_t m_r;
  hpsg_pkg::hpsg_mux_t m_nxt;

  always_comb
  begin
    m_nxt = m_r;
    if (pif.host_mode)
    begin
      m_nxt.drv = pif.drv_host;
      m_nxt.oe = pif.oe_host;
    end
    else
    begin
      m_nxt.drv = pif.gpio_data; // R3
      m_nxt.oe = pif.gpio_dir; // R3
    end
  end

  // reset leaves every pin undriven
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      m_r <= '0; // R1
    else
      m_r <= m_nxt;
  end

  assign pif.pin_out = m_r.drv;
  assign pif.pin_oe = m_r.oe;
endmodule

// ### rtl/hpsg_top.sv
/*
  Host port service and GPIO fallback: host-visible registers, flags,
  request outputs, vector drive, dsp-side register port and pin control.
  Assumes a synchronous dsp-side register master and a host on pins that
  holds address and data steady around each strobe for several clocks.
*/
// Notes on behaviour
// [R1] reset clears control, direction, data; pins float
// [R2] control bits 6..1 set selects host port
// [R3] gpio pin drives data when direction bit set
// [R4] host drives address, direction, data, then strobe
// [R5] polling host keeps acknowledge deasserted
// [R6] receive-full means host may read word
// [R7] transmit-empty means host may write word
// [R8] ready word passes straight to dsp side
// [R9] dsp flags two, three shown in status
// [R10] request status equals asserted request output
// [R11] status flag follows each data transfer
// [R12] command pending clears when dsp accepts
// [R13] request asserted by flag and enable
// [R14] host routine transfers data to drop request
// [R15] request drops on clear, mask or reset
// [R16] vector driven while request and acknowledge
// [R17] byte order select maps bytes 7,6,5
// [R18] address 7 access clears its flag
// [R19] full transmit word moves to dsp receive
// [R20] reset loads vector register with 0x0F
// [R21] gpio mode: no requests, strobes ignored
// [R22] host pins synchronised before any use
`timescale 1ns/10ps
`include "hpsg_map.svh"
module hpsg_top (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [23:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [23:0] reg_rdata_out,
  input wire logic [`HPSG_NPINS-1:0] pin_in,
  output logic [`HPSG_NPINS-1:0] pin_out,
  output logic [`HPSG_NPINS-1:0] pin_oe_out,
  output logic tx_request_out,
  output logic rx_request_out,
  output logic host_request_out
);
  hpsg_pkg::hpsg_core_t c_r;
  hpsg_pkg::hpsg_core_t c_nxt;
  hpsg_pin_if pif ();

  logic host_mode;
  logic [2:0] h_addr;
  logic [7:0] h_data;
  logic h_rd;
  logic h_wr;
  logic h_ack;
  logic rd_rise;
  logic wr_rise;
  logic tx_ready;
  logic host_cmd_set;
  logic [7:0] interface_status_reg;
  logic [1:0] lane;

  // maps a data address to a byte lane of the 24-bit word
  function automatic logic [1:0] byte_lane(input logic [2:0] a, input logic order);
    logic [1:0] l;
    l = `HPSG_LANE_MID;
    if (a == `HPSG_HA_B7)
      l = order ? `HPSG_LANE_HI : `HPSG_LANE_LO; // R17
    else if (a == `HPSG_HA_B5)
      l = order ? `HPSG_LANE_LO : `HPSG_LANE_HI; // R17
    return l;
  endfunction

  hpsg_sync u_sync (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .pif(pif.sync_mp)
  );

  hpsg_pinmux u_mux (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .pif(pif.mux_mp)
  );

  // partly set mode bits count as gpio
  assign host_mode = &c_r.pctl[`HPSG_MODE_MSB:`HPSG_MODE_LSB]; // R2
  assign pif.raw = pin_in;
  assign pif.host_mode = host_mode;
  assign pif.gpio_dir = c_r.pdir;
  assign pif.gpio_data = c_r.pdat;

  // only synchronised copies are read; read and write strobes act on their rising edge, acknowledge on its level
  assign h_addr = pif.sampled[`HPSG_P_AMSB:`HPSG_P_ALSB]; // R22
  assign h_data = pif.sampled[`HPSG_P_DMSB:0];
  assign h_rd = pif.sampled[`HPSG_P_RD];
  assign h_wr = pif.sampled[`HPSG_P_WR];
  assign h_ack = pif.sampled[`HPSG_P_ACK];
  assign rd_rise = host_mode && h_rd && !c_r.rd_d; // R21
  assign wr_rise = host_mode && h_wr && !c_r.wr_d; // R21
  assign lane = byte_lane(h_addr, c_r.icr[`HPSG_ICR_ORDER]);
  assign host_cmd_set = wr_rise && h_addr == `HPSG_HA_CMD && h_data[`HPSG_CMD_PEND];
  assign tx_ready = c_r.tx_empty && !c_r.dsp_rx_full; // R8

  assign interface_status_reg[`HPSG_ISR_RXF] = c_r.rx_full; // R6
  assign interface_status_reg[`HPSG_ISR_TXE] = c_r.tx_empty; // R7
  assign interface_status_reg[`HPSG_ISR_TX_READY_FLAG] = tx_ready; // R8
  assign interface_status_reg[`HPSG_ISR_F2] = c_r.dflags[0]; // R9
  assign interface_status_reg[`HPSG_ISR_F3] = c_r.dflags[1]; // R9
  assign interface_status_reg[`HPSG_ISR_R5] = 1'b0;
  assign interface_status_reg[`HPSG_ISR_R6] = 1'b0;
  assign interface_status_reg[`HPSG_ISR_REQ] = c_r.request_status_flag; // R10

  // the two request pins are always driven in host mode, the data pins only while c_r.hoe is set
  always_comb
  begin
    pif.drv_host = '0;
    pif.oe_host = '0;
    pif.drv_host[`HPSG_P_DMSB:0] = c_r.hdo;
    pif.oe_host[`HPSG_P_DMSB:0] = {8{c_r.hoe}};
    pif.drv_host[`HPSG_P_TX_REQUEST_ENABLE] = c_r.tx_request_enable;
    pif.drv_host[`HPSG_P_RX_REQUEST_ENABLE] = c_r.rx_request_enable;
    pif.oe_host[`HPSG_P_TX_REQUEST_ENABLE] = 1'b1;
    pif.oe_host[`HPSG_P_RX_REQUEST_ENABLE] = 1'b1;
  end

  always_comb
  begin
    c_nxt = c_r;
    c_nxt.rdata = '0;
    c_nxt.rd_d = h_rd;
    c_nxt.wr_d = h_wr;
    // host side accesses
    if (host_mode)
    begin
      if (rd_rise && h_addr == `HPSG_HA_B7)
        c_nxt.rx_full = 1'b0; // R18
      if (wr_rise)
      begin
        case (h_addr)
          `HPSG_HA_CTRL: c_nxt.icr = h_data;
          `HPSG_HA_CMD: c_nxt.cmd_vec = h_data[6:0];
          `HPSG_HA_VEC: c_nxt.vec = h_data;
          `HPSG_HA_B5, `HPSG_HA_B6, `HPSG_HA_B7:
          begin
            c_nxt.txw[{lane, 3'h0} +: 8] = h_data; // R17
            if (h_addr == `HPSG_HA_B7)
              c_nxt.tx_empty = 1'b0; // R18
          end
          default: ;
        endcase
      end
      if (host_cmd_set)
        c_nxt.cmd_pend = 1'b1;
    end
    else
    begin
      // outside host mode the word flags read empty and command pending clears; the word registers keep their contents
      c_nxt.tx_empty = 1'b1;
      c_nxt.rx_full = 1'b0;
      c_nxt.cmd_pend = 1'b0;
    end
    // dsp side register port
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        `HPSG_DA_PCTL: c_nxt.pctl = reg_wdata_in[7:0]; // R2
        `HPSG_DA_PDIR: c_nxt.pdir = reg_wdata_in[15:0];
        `HPSG_DA_PDAT: c_nxt.pdat = reg_wdata_in[15:0];
        `HPSG_DA_FLAGS: c_nxt.dflags = reg_wdata_in[1:0]; // R9
        `HPSG_DA_TX:
        begin
          // no overrun guard: the dsp must see receive-full clear first
          c_nxt.rxw = reg_wdata_in;
          c_nxt.rx_full = 1'b1; // R11
        end
        `HPSG_DA_CACK: c_nxt.cmd_pend = host_cmd_set; // R12
        default: ;
      endcase
    end
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `HPSG_DA_PCTL: c_nxt.rdata = 24'(c_r.pctl);
        `HPSG_DA_PDIR: c_nxt.rdata = 24'(c_r.pdir);
        `HPSG_DA_PDAT: c_nxt.rdata = 24'((c_r.pdat & c_r.pdir) | (pif.sampled & ~c_r.pdir));
        `HPSG_DA_RX:
        begin
          c_nxt.rdata = c_r.dsp_rx;
          c_nxt.dsp_rx_full = 1'b0;
        end
        `HPSG_DA_STAT: c_nxt.rdata = 24'({c_r.cmd_pend, c_r.dsp_rx_full});
        `HPSG_DA_FLAGS: c_nxt.rdata = 24'(c_r.dflags);
        default: c_nxt.rdata = '0;
      endcase
    end
    // word transfer to the dsp side; runs after the clears so sets win
    if (!c_r.tx_empty && !c_r.dsp_rx_full)
    begin
      c_nxt.dsp_rx = c_r.txw; // R19
      c_nxt.tx_empty = 1'b1; // R11
      c_nxt.dsp_rx_full = 1'b1; // R19
    end
    // host read data; vector takes the bus during acknowledge while the request status flag is set
    if (h_ack && c_r.request_status_flag)
      c_nxt.hdo = c_r.vec; // R16
    else
    begin
      case (h_addr)
        `HPSG_HA_CTRL: c_nxt.hdo = c_r.icr;
        `HPSG_HA_CMD: c_nxt.hdo = {c_r.cmd_pend, c_r.cmd_vec};
        `HPSG_HA_STAT: c_nxt.hdo = interface_status_reg;
        `HPSG_HA_VEC: c_nxt.hdo = c_r.vec;
        `HPSG_HA_B5, `HPSG_HA_B6, `HPSG_HA_B7: c_nxt.hdo = c_r.rxw[{lane, 3'h0} +: 8];
        default: c_nxt.hdo = '0;
      endcase
    end
    c_nxt.hoe = host_mode && (h_rd || (h_ack && c_r.request_status_flag)); // R16
    c_nxt.tx_request_enable = host_mode && c_r.icr[`HPSG_ICR_TX_REQUEST_ENABLE] && c_r.tx_empty; // R13 R15
    c_nxt.rx_request_enable = host_mode && c_r.icr[`HPSG_ICR_RX_REQUEST_ENABLE] && c_r.rx_full; // R13 R15
    c_nxt.request_status_flag = c_nxt.tx_request_enable || c_nxt.rx_request_enable; // R10
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      c_r <= '0; // R1
      c_r.tx_empty <= 1'b1;
      c_r.vec <= `HPSG_VEC_RST; // R20
      c_r.cmd_vec <= `HPSG_CMDV_RST;
    end
    else
      c_r <= c_nxt;
  end

  assign reg_rdata_out = c_r.rdata;
  assign pin_out = pif.pin_out;
  assign pin_oe_out = pif.pin_oe;
  assign tx_request_out = c_r.tx_request_enable;
  assign rx_request_out = c_r.rx_request_enable;
  assign host_request_out = c_r.request_status_flag;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  reset_state_a: assert property ( // R1
    disable iff (1'b0) sys_rst_in |=> c_r.pctl == '0 && c_r.pdir == '0 && c_r.pdat == '0
      && c_r.vec == `HPSG_VEC_RST ##1 pin_oe_out == '0)
    else $error("reset left port configured");
  gpio_drive_a: assert property ( // R3
    !host_mode |=> pin_oe_out == $past(c_r.pdir) && pin_out == $past(c_r.pdat))
    else $error("gpio pins not following direction and data");
  mode_pins_a: assert property ( // R2
    host_mode |=> pin_oe_out[`HPSG_P_TX_REQUEST_ENABLE] && pin_oe_out[`HPSG_P_RX_REQUEST_ENABLE])
    else $error("host mode request pins not driven");
  gpio_quiet_a: assert property ( // R21
    !host_mode |=> !tx_request_out && !rx_request_out && !host_request_out)
    else $error("request raised in gpio mode");
  tx_request_a: assert property ( // R13
    host_mode && c_r.icr[`HPSG_ICR_TX_REQUEST_ENABLE] && c_r.tx_empty |=> tx_request_out)
    else $error("transmit request missing");
  rx_mask_a: assert property ( // R15
    !c_r.icr[`HPSG_ICR_RX_REQUEST_ENABLE] |=> !rx_request_out)
    else $error("receive request not masked");
  status_req_a: assert property ( // R10
    interface_status_reg[`HPSG_ISR_REQ] == (tx_request_out || rx_request_out))
    else $error("request status differs from outputs");
  vector_drive_a: assert property ( // R16
    h_ack && host_request_out && host_mode |=> c_r.hoe && c_r.hdo == $past(c_r.vec)
      ##1 pin_oe_out[0])
    else $error("vector not driven on acknowledge");
  rx_clear_a: assert property ( // R18
    rd_rise && h_addr == `HPSG_HA_B7 && !(reg_wr_in && reg_addr_in == `HPSG_DA_TX)
      |=> !c_r.rx_full)
    else $error("receive flag not cleared by read");
  word_move_a: assert property ( // R19
    !c_r.tx_empty && !c_r.dsp_rx_full |=> c_r.tx_empty && c_r.dsp_rx_full
      && c_r.dsp_rx == $past(c_r.txw))
    else $error("transmit word not moved");
  cmd_accept_a: assert property ( // R12
    reg_wr_in && reg_addr_in == `HPSG_DA_CACK && !host_cmd_set |=> !c_r.cmd_pend)
    else $error("command pending not cleared");
  flag_show_a: assert property ( // R9
    reg_wr_in && reg_addr_in == `HPSG_DA_FLAGS |=>
      interface_status_reg[`HPSG_ISR_F3:`HPSG_ISR_F2] == $past(reg_wdata_in[1:0]))
    else $error("dsp flags not shown in status");
  tx_mask_a: assert property ( // R15
    !c_r.icr[`HPSG_ICR_TX_REQUEST_ENABLE] |=> !tx_request_out)
    else $error("transmit request not masked");
  // the transfer needs the flag already clear, so it cannot refill it here
  tx_clear_a: assert property ( // R18
    wr_rise && h_addr == `HPSG_HA_B7 && c_r.tx_empty |=> !c_r.tx_empty)
    else $error("transmit flag not cleared by write");

  word_move_c: cover property (!c_r.tx_empty && !c_r.dsp_rx_full ##1 c_r.dsp_rx_full);
  vector_ack_c: cover property (h_ack && host_request_out ##1 c_r.hoe);
  // host cycles take over a dozen clocks, so the windows are wide
  cmd_accept_c: cover property (c_r.cmd_pend ##[1:60] !c_r.cmd_pend);
  rx_drain_c: cover property (c_r.rx_full ##[1:120] !c_r.rx_full);
endmodule

// ### test/hpsg_host_model.sv
/*
  Host processor model on the port pins: static-ram style cycles and the vector cycle.
  Assumes the bench resolves nothing itself; released lines show the inverse of their last level.
*/
`timescale 1ns/10ps
module hpsg_host_model (
  input wire logic sys_clk_in,
  input wire logic [15:0] pin_drv_in,
  input wire logic [15:0] pin_oe_in,
  output logic [15:0] pin_level_out
);
  logic [15:0] drv = 16'h0000;
  logic [15:0] hoe = 16'hFFFF;
  logic [15:0] last_r = 16'h0000;
  int hangs = 0;
  // no pull resistors: a floating line must not look like a held value
  assign pin_level_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & hoe & drv)
    | (~pin_oe_in & ~hoe & ~last_r);
  always @(posedge sys_clk_in) last_r <= pin_level_out;
  // s picks the strobe pin: 11 read, 12 write, 13 acknowledge
  task automatic cyc(input logic [2:0] a, input int s, input logic [7:0] wd,
    output logic [7:0] rd);
    int n;
    @(posedge sys_clk_in);
    drv[10:8] <= a;
    drv[7:0] <= wd;
    hoe[7:0] <= (s == 12) ? 8'hFF : 8'h00;
    repeat (3) @(posedge sys_clk_in);
    drv[s] <= 1'b1;
    repeat (5) @(negedge sys_clk_in);
    n = 0;
    while (s != 12 && pin_oe_in[0] !== 1'b1 && n < 8)
    begin
      @(negedge sys_clk_in);
      n++;
    end
    if (n == 8) hangs++;
    rd = pin_level_out[7:0];
    @(posedge sys_clk_in);
    drv[s] <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    hoe[7:0] <= 8'h00;
    repeat (2) @(posedge sys_clk_in);
  endtask
endmodule

// ### test/test_host_port_service_gpio.sv
/*
  Self-checking bench: register port, gpio fallback, host polling, requests,
  vector cycle, byte order, word transfer both ways and command handshake.
  Assumes the host model on the pins; assertions live in the design files.
*/
`timescale 1ns/10ps
`include "hpsg_map.svh"
module test_host_port_service_gpio;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [23:0] reg_wdata_in = 24'h000000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [23:0] reg_rdata_out;
  logic [15:0] pin_in;
  logic [15:0] pin_out;
  logic [15:0] pin_oe_out;
  logic tx_request_out;
  logic rx_request_out;
  logic host_request_out;
  logic rd_q = 1'b0;
  logic [23:0] exp_q[$];
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 13;
  int o;
  logic [23:0] w;
  logic [23:0] w2;
  logic [15:0] dir;
  logic [15:0] dat;
  logic [15:0] p;
  logic [7:0] b;
  logic [7:0] v;
  hpsg_top DUT (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .tx_request_out(tx_request_out),
    .rx_request_out(rx_request_out), .host_request_out(host_request_out));
  hpsg_host_model host_m (.sys_clk_in(sys_clk_in), .pin_drv_in(pin_out),
    .pin_oe_in(pin_oe_out), .pin_level_out(pin_in));
  initial forever #5 sys_clk_in = ~sys_clk_in;
  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] expv);
    samples_checked++;
    if (seen !== expv)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic summarize();
    mismatches += host_m.hangs;
    // a read whose data never got compared counts against the run
    if (exp_q.size() != 0) mismatches++;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe, so compare there
  always @(posedge sys_clk_in) rd_q <= reg_rd_in;
  always @(negedge sys_clk_in)
  begin
    if (rd_q && exp_q.size() > 0) chk("reg_rdata_out", reg_rdata_out, exp_q.pop_front());
  end
  task automatic reg_wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [23:0] e);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge sys_clk_in);
  endtask
  task automatic hwr(input logic [2:0] a, input logic [7:0] d);
    host_m.cyc(a, 12, d, b);
  endtask
  task automatic hrd(input logic [2:0] a, input logic [7:0] e, input string name);
    host_m.cyc(a, 11, 8'h00, b);
    chk(name, {16'h0000, b}, {16'h0000, e});
  endtask
  // the byte that lands at address 7 is written last, it completes the word
  task automatic hword(input int ord, input logic [23:0] d);
    int a;
    for (a = 5; a < 8; a++) hwr(a[2:0], ord ? d[8*(a-5) +: 8] : d[8*(7-a) +: 8]);
  endtask
  initial
  begin
    #400000;
    mismatches++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    reg_rd(`HPSG_DA_PCTL, 24'h000000);
    reg_rd(`HPSG_DA_PDIR, 24'h000000);
    reg_rd(`HPSG_DA_PDAT, 24'h000000);
    reg_rd(4'h9, 24'h000000);
    chk("pin_oe_out", {8'h00, pin_oe_out}, 24'h000000);
    dir = 16'($random(seed));
    dat = 16'($random(seed));
    p = 16'($random(seed));
    @(posedge sys_clk_in);
    host_m.drv <= p;
    host_m.hoe <= ~dir;
    reg_wr(4'hA, 24'hFFFFFF);
    reg_wr(`HPSG_DA_PDIR, {8'h00, dir});
    reg_wr(`HPSG_DA_PDAT, {8'h00, dat});
    reg_wr(`HPSG_DA_PCTL, 24'h00007C);
    repeat (4) @(negedge sys_clk_in);
    chk("pin_oe_out", {8'h00, pin_oe_out}, {8'h00, dir});
    chk("pin_out", {8'h00, pin_out & dir}, {8'h00, dat & dir});
    reg_rd(`HPSG_DA_PDAT, {8'h00, (dat & dir) | (p & ~dir)});
    chk("host_request_out", {23'h0, host_request_out}, 24'h000000);
    reg_wr(`HPSG_DA_PDIR, 24'h000000);
    host_m.drv <= 16'h0000;
    host_m.hoe <= 16'h3F00;
    reg_wr(`HPSG_DA_PCTL, 24'h00007E);
    repeat (4) @(posedge sys_clk_in);
    hrd(`HPSG_HA_STAT, 8'h06, "status");
    hrd(`HPSG_HA_VEC, 8'h0F, "vector");
    hrd(`HPSG_HA_CMD, 8'h32, "command");
    v = 8'($random(seed));
    hwr(`HPSG_HA_VEC, v);
    hwr(`HPSG_HA_CTRL, 8'h02);
    repeat (4) @(negedge sys_clk_in);
    chk("tx_request_out", {23'h0, tx_request_out}, 24'h000001);
    hrd(`HPSG_HA_STAT, 8'h86, "status");
    host_m.cyc(3'h0, 13, 8'h00, b);
    chk("vector drive", {16'h0000, b}, {16'h0000, v});
    for (o = 0; o < 2; o++)
    begin
      w = 24'($random(seed));
      w2 = 24'($random(seed));
      hwr(`HPSG_HA_CTRL, o ? 8'h22 : 8'h02);
      hword(o, w);
      hrd(`HPSG_HA_STAT, 8'h82, "status");
      reg_rd(`HPSG_DA_STAT, 24'h000001);
      hword(o, w2);
      hrd(`HPSG_HA_STAT, 8'h00, "status");
      chk("tx_request_out", {23'h0, tx_request_out}, 24'h000000);
      reg_rd(`HPSG_DA_RX, w);
      repeat (3) @(posedge sys_clk_in);
      reg_rd(`HPSG_DA_RX, w2);
      hrd(`HPSG_HA_STAT, 8'h86, "status");
    end
    w = 24'($random(seed));
    reg_wr(`HPSG_DA_TX, w);
    reg_wr(`HPSG_DA_FLAGS, 24'h000003);
    reg_rd(`HPSG_DA_FLAGS, 24'h000003);
    hwr(`HPSG_HA_CTRL, 8'h01);
    hrd(`HPSG_HA_STAT, 8'h9F, "status");
    chk("rx_request_out", {23'h0, rx_request_out}, 24'h000001);
    for (o = 5; o < 8; o++) hrd(o[2:0], w[8*(7-o) +: 8], "rx byte");
    chk("rx_request_out", {23'h0, rx_request_out}, 24'h000000);
    hrd(`HPSG_HA_STAT, 8'h1E, "status");
    hwr(`HPSG_HA_CMD, {1'b1, v[6:0]});
    reg_rd(`HPSG_DA_STAT, 24'h000002);
    hrd(`HPSG_HA_CMD, {1'b1, v[6:0]}, "command");
    reg_wr(`HPSG_DA_CACK, 24'h000000);
    hrd(`HPSG_HA_CMD, {1'b0, v[6:0]}, "command");
    hwr(`HPSG_HA_CTRL, 8'h02);
    repeat (4) @(negedge sys_clk_in);
    chk("host_request_out", {23'h0, host_request_out}, 24'h000001);
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(negedge sys_clk_in);
    chk("host_request_out", {23'h0, host_request_out}, 24'h000000);
    chk("pin_oe_out", {8'h00, pin_oe_out}, 24'h000000);
    reg_rd(`HPSG_DA_PCTL, 24'h000000);
    // a control write in gpio mode must not survive into host mode
    hwr(`HPSG_HA_CTRL, 8'h02);
    reg_wr(`HPSG_DA_PCTL, 24'h00007E);
    repeat (4) @(negedge sys_clk_in);
    chk("tx_request_out", {23'h0, tx_request_out}, 24'h000000);
    // the last queued read was compared at the negedge ending its register read, before the host cycles; one more clock before the verdict
    @(posedge sys_clk_in);
    summarize();
  end
endmodule
